// ==== inc/stx_pkg.sv ====
// Package for the skip, table read and XOR execution block
package stx_pkg;
  // ==========================================================
  // Widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int PADDR_W = 12;
  localparam int PWORD_W = 16;
  localparam int BIT_SEL_W = 3;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
  localparam logic [PADDR_W-1:0] RESET_PADDR = 12'h000;

  // ==========================================================
  // Operation codes
  typedef enum logic [3:0] {
    STX_OP_NONE = 4'h0,
    STX_OP_SKIP_IF_BYTE_ZERO = 4'h1,
    STX_OP_COPY_SKIP_IF_ZERO = 4'h2,
    STX_OP_SKIP_IF_BIT_ZERO = 4'h3,
    STX_OP_TABLE_READ_PAGED = 4'h4,
    STX_OP_TABLE_READ_LAST_PAGE = 4'h5,
    STX_OP_XOR_TO_ACC = 4'h6,
    STX_OP_XOR_TO_MEMORY = 4'h7,
    STX_OP_XOR_IMMEDIATE = 4'h8
  } stx_op_e;

  // Execution states, Gray along the table-read path; idle to dummy flips both bits
  typedef enum logic [1:0] {
    STX_ST_IDLE = 2'b00,
    STX_ST_TABLE = 2'b01,
    STX_ST_DUMMY = 2'b11
  } stx_state_e;

  // ==========================================================
  // Request carried into the block
  typedef struct packed {
    stx_op_e op;
    logic [ADDR_W-1:0] addr;
    logic [BIT_SEL_W-1:0] bitSel;
    logic [DATA_W-1:0] immediate;
  } stx_req_s;

  // Data-memory write carried out of the block
  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } stx_mem_wr_s;
endpackage : stx_pkg

// ==== testbench/skip_table_xor_exec_tb.sv ====
// Self-checking bench for the skip, table read and XOR execution block
`timescale 1ns/1ps
module skip_table_xor_exec_tb;
  import stx_pkg::*;
  typedef struct {
    logic [7:0] acc, tbh, wa, wd;
    logic zf, we, sk, re;
    logic [11:0] pa;
    int lat, t;
  } stx_note_s;
  logic clock = 1'b0, reset = 1'b1, reqValid = 1'b0;
  stx_req_s req = '0;
  logic [7:0] memRdData = 8'h00, tablePointerLow = 8'h00, tablePointerHigh = 8'h00;
  logic [15:0] progWord = 16'h0000, r = 16'h0004;
  logic busy, progRdEn, zeroFlag, skipNext, done;
  logic [11:0] progAddr, rA, pa;
  stx_mem_wr_s memWr;
  logic [7:0] acc, tableHighByteLatch, mAcc = 8'h00, mTbh = 8'h00, wA, wD;
  logic mZf = 1'b0, wS = 1'b0, sS = 1'b0, rS = 1'b0;
  int err_count = 0, compares = 0, cyc = 0, ph = 0, guard;
  stx_note_s q[$];
  stx_note_s n, o;

  skip_table_xor_exec skip_table_xor_exec_inst (.clock(clock), .reset(reset),
    .reqValid(reqValid), .req(req), .memRdData(memRdData), .tablePointerLow(tablePointerLow),
    .tablePointerHigh(tablePointerHigh), .progWord(progWord), .busy(busy),
    .progAddr(progAddr), .progRdEn(progRdEn), .memWr(memWr), .acc(acc),
    .tableHighByteLatch(tableHighByteLatch), .zeroFlag(zeroFlag), .skipNext(skipNext),
    .done(done));

  // ==========================================================
  // Clock, cycle count and helpers
  always #2.5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;

  function automatic logic [15:0] nx(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : nx

  function automatic logic [15:0] rom(input logic [11:0] a);
    return {a[11:4] ^ 8'h3C, a[7:0] ^ 8'hA5};
  endfunction : rom

  task automatic chkV(input logic [23:0] g, input logic [23:0] e, input string m);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chkV

  task automatic end_of_test();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  // ==========================================================
  // Program memory answers fetches, else shows a changing pattern
  always @(negedge clock) begin
    if (progRdEn === 1'b1) begin
      pa = progAddr;
      ph = 2;
    end
    progWord <= (ph > 0) ? rom(pa) : ~progWord;
    if (ph > 0) ph = ph - 1;
  end

  // ==========================================================
  // Monitor: gathers pulses, compares against the oldest note at done
  always @(negedge clock) begin
    if (reset === 1'b0) begin
      if (memWr.en === 1'b1) {wS, wA, wD} = {1'b1, memWr.addr, memWr.data};
      if (skipNext === 1'b1) sS = 1'b1;
      if (progRdEn === 1'b1) {rS, rA} = {1'b1, progAddr};
      if (done === 1'b1) begin
        if (q.size() == 0) chkV(24'h1, 24'h0, "done without request");
        else begin
          o = q.pop_front();
          chkV(24'(cyc - o.t), 24'(o.lat), "latency");
          chkV({23'h0, sS}, {23'h0, o.sk}, "skip");
          chkV({7'h0, wS, wA, wD}, {7'h0, o.we, o.wa, o.wd}, "write");
          chkV({11'h0, rS, rA}, {11'h0, o.re, o.pa}, "fetch");
          chkV({7'h0, zeroFlag, acc, tableHighByteLatch}, {7'h0, o.zf, o.acc, o.tbh},
            "state");
        end
        {wS, sS, rS, wA, wD, rA} = '0;
      end
    end
    else {wS, sS, rS, wA, wD, rA} = '0;
  end

  // ==========================================================
  // Driver: notes the expected result, issues one request
  task automatic exec(input stx_op_e op, input logic [7:0] a, m, imm, lo, hi,
                      input logic [2:0] b);
    logic [15:0] w;
    n = '{default: 0};
    n.t = cyc;
    n.sk = (op inside {STX_OP_SKIP_IF_BYTE_ZERO, STX_OP_COPY_SKIP_IF_ZERO}) ? (m == 8'h00)
         : (op == STX_OP_SKIP_IF_BIT_ZERO) ? ~m[b] : 1'b0;
    n.re = op inside {STX_OP_TABLE_READ_PAGED, STX_OP_TABLE_READ_LAST_PAGE};
    n.pa = n.re ? {(op == STX_OP_TABLE_READ_LAST_PAGE) ? 4'hF : hi[3:0], lo} : 12'h000;
    w = rom(n.pa);
    if (op == STX_OP_COPY_SKIP_IF_ZERO) mAcc = m;
    if (op == STX_OP_XOR_TO_ACC) mAcc = mAcc ^ m;
    if (op == STX_OP_XOR_IMMEDIATE) mAcc = mAcc ^ imm;
    n.we = n.re || op inside {STX_OP_SKIP_IF_BYTE_ZERO, STX_OP_XOR_TO_MEMORY};
    n.wa = n.we ? a : 8'h00;
    n.wd = !n.we ? 8'h00 : n.re ? w[7:0] : (op == STX_OP_XOR_TO_MEMORY) ? mAcc ^ m : m;
    if (n.re) mTbh = w[15:8];
    if (op inside {STX_OP_XOR_TO_ACC, STX_OP_XOR_IMMEDIATE}) mZf = (mAcc == 8'h00);
    if (op == STX_OP_XOR_TO_MEMORY) mZf = (n.wd == 8'h00);
    n.lat = (n.sk || n.re) ? 2 : 1;
    {n.acc, n.zf, n.tbh} = {mAcc, mZf, mTbh};
    req = '{op: op, addr: a, bitSel: b, immediate: imm};
    {memRdData, tablePointerLow, tablePointerHigh} = {m, lo, hi};
    reqValid = 1'b1;
    q.push_back(n);
    @(negedge clock);
    guard = 0;
    // Requests while busy must be ignored
    while (busy === 1'b1 && guard < 8) begin
      r = nx(r);
      req.op = STX_OP_XOR_IMMEDIATE;
      {req.immediate, memRdData, tablePointerLow} = {r[7:0], r[15:8], r[11:4]};
      guard++;
      @(negedge clock);
    end
  endtask : exec

  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(negedge clock);
    reset = 1'b0;
    chkV({6'h0, busy, zeroFlag, acc, tableHighByteLatch}, 24'h0, "reset state");
    for (int k = 0; k < 8; k++) begin
      exec(STX_OP_SKIP_IF_BIT_ZERO, 8'h10, ~(8'h01 << k), 8'h00, 8'h00, 8'h00, 3'(k));
      exec(STX_OP_SKIP_IF_BIT_ZERO, 8'h11, 8'h01 << k, 8'h00, 8'h00, 8'h00, 3'(k));
    end
    for (int k = 0; k < 18; k++)
      exec(stx_op_e'(4'(k % 9)), 8'(k), (k < 9) ? 8'h00 : 8'h5A, 8'hC3, 8'hFF, 8'hFF, 3'h0);
    exec(STX_OP_XOR_IMMEDIATE, 8'h20, 8'h00, 8'h81, 8'h00, 8'h00, 3'h0);
    exec(STX_OP_XOR_TO_MEMORY, 8'h21, mAcc, 8'h00, 8'h00, 8'h00, 3'h0);
    exec(STX_OP_XOR_TO_ACC, 8'h22, mAcc, 8'h00, 8'h00, 8'h00, 3'h0);
    exec(STX_OP_XOR_IMMEDIATE, 8'h23, 8'h00, 8'h7E, 8'h00, 8'h00, 3'h0);
    exec(STX_OP_XOR_IMMEDIATE, 8'h24, 8'h00, mAcc, 8'h00, 8'h00, 3'h0);
    for (int k = 0; k < 200; k++) begin
      r = nx(nx(r));
      exec(stx_op_e'(4'(r[3:0] % 9)), r[15:8], r[4] ? 8'h00 : r[15:8] ^ r[11:4], r[11:4],
           r[7:0], r[15:8], r[7:5]);
    end
    // Reset in mid-run returns the state to zero
    reqValid = 1'b0;
    repeat (3) @(negedge clock);
    reset = 1'b1;
    {mAcc, mZf, mTbh} = '0;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    chkV({6'h0, busy, zeroFlag, acc, tableHighByteLatch}, 24'h0, "reset state again");
    exec(STX_OP_XOR_IMMEDIATE, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0);
    reqValid = 1'b0;
    repeat (3) @(negedge clock);
    chkV(24'(q.size()), 24'h0, "pending notes");
    end_of_test();
  end

  // Watchdog against a hang
  initial begin
    #60000;
    err_count++;
    end_of_test();
  end
endmodule : skip_table_xor_exec_tb

// ==== verilog/skip_table_xor_exec.sv ====
// Execution unit for zero-skip, table-read and XOR instructions
// Contract
// - Byte zero-skip reads byte, writes it back, skips next when zero.
// - A taken skip inserts one dummy cycle, so the skip takes two cycles.
// - Nonzero tested value continues with the next instruction.
// - Copy-and-skip loads byte into accumulator, skips when zero.
// - Bit zero-skip tests selected bit, skips when that bit is zero.
// - Skip and table-read instructions leave all status flags alone.
// - Paged read fetches word at high and low pointers into memory and latch.
// - Last-page read fetches word on last page at low pointer.
// - XOR to accumulator from memory updates only the zero flag.
// - XOR result written back to memory, only zero flag updated.
// - XOR with immediate into accumulator, only zero flag updated.
// - Test and write-back use the value held at instruction start.
`timescale 1ns/1ps
module skip_table_xor_exec #(
  parameter int HIGH_PTR_BITS = 4,
  parameter bit HAS_HIGH_PTR = 1'b1
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic reqValid,
  input wire stx_pkg::stx_req_s req,
  input wire logic [stx_pkg::DATA_W-1:0] memRdData,
  input wire logic [stx_pkg::DATA_W-1:0] tablePointerLow,
  input wire logic [stx_pkg::DATA_W-1:0] tablePointerHigh,
  input wire logic [stx_pkg::PWORD_W-1:0] progWord,
  output logic busy,
  output logic [stx_pkg::PADDR_W-1:0] progAddr,
  output logic progRdEn,
  output stx_pkg::stx_mem_wr_s memWr,
  output logic [stx_pkg::DATA_W-1:0] acc,
  output logic [stx_pkg::DATA_W-1:0] tableHighByteLatch,
  output logic zeroFlag,
  output logic skipNext,
  output logic done
);
  import stx_pkg::*;

  localparam int PAGE_BITS = PADDR_W - DATA_W;

  // ==========================================================
  // Elaboration checks
  if (HIGH_PTR_BITS < 1 || HIGH_PTR_BITS > PAGE_BITS) begin : gBadHighPtr
    $error("HIGH_PTR_BITS must lie between one and the page field width");
  end

  // Page-selectable table address: high pointer when present, else low only
  function automatic logic [PADDR_W-1:0] pagedAddr(input logic [DATA_W-1:0] hi,
                                                   input logic [DATA_W-1:0] lo);
    logic [PAGE_BITS-1:0] page;
    page = '0;
    if (HAS_HIGH_PTR) begin
      page = PAGE_BITS'(hi[HIGH_PTR_BITS-1:0]);
    end
    return {page, lo};
  endfunction : pagedAddr

  // ==========================================================
  // State
  stx_state_e state_r, state_nxt;
  stx_op_e tableOp_r, tableOp_nxt;
  logic [ADDR_W-1:0] tableDst_r, tableDst_nxt;
  logic [PADDR_W-1:0] progAddr_r, progAddr_nxt;
  logic progRdEn_r, progRdEn_nxt;
  stx_mem_wr_s memWr_r, memWr_nxt;
  logic [DATA_W-1:0] acc_r, acc_nxt;
  logic [DATA_W-1:0] tbl_r, tbl_nxt;
  logic zero_r, zero_nxt;
  logic skip_r, skip_nxt;
  logic done_r, done_nxt;
  logic busy_r, busy_nxt;
  logic [DATA_W-1:0] xorResult;
  logic skipTaken;

  // Compute unit
  stx_alu stx_alu_inst (
    .op(req.op),
    .acc(acc_r),
    .memData(memRdData),
    .immediate(req.immediate),
    .bitSel(req.bitSel),
    .xorResult(xorResult),
    .skipTaken(skipTaken)
  );

  // ==========================================================
  // Next-state and datapath
  always_comb begin
    state_nxt = state_r;
    tableOp_nxt = tableOp_r;
    tableDst_nxt = tableDst_r;
    progAddr_nxt = progAddr_r;
    progRdEn_nxt = 1'b0;
    memWr_nxt = '0;
    acc_nxt = acc_r;
    tbl_nxt = tbl_r;
    zero_nxt = zero_r;
    skip_nxt = 1'b0;
    done_nxt = 1'b0;
    unique case (state_r)
      STX_ST_IDLE: begin
        if (reqValid) begin
          unique case (req.op)
            STX_OP_SKIP_IF_BYTE_ZERO: begin
              memWr_nxt = '{en: 1'b1, addr: req.addr, data: memRdData};
            end
            STX_OP_COPY_SKIP_IF_ZERO: begin
              acc_nxt = memRdData;
            end
            STX_OP_TABLE_READ_PAGED: begin
              progAddr_nxt = pagedAddr(tablePointerHigh, tablePointerLow);
              progRdEn_nxt = 1'b1;
            end
            STX_OP_TABLE_READ_LAST_PAGE: begin
              progAddr_nxt = {{PAGE_BITS{1'b1}}, tablePointerLow};
              progRdEn_nxt = 1'b1;
            end
            STX_OP_XOR_TO_ACC, STX_OP_XOR_IMMEDIATE: begin
              acc_nxt = xorResult;
              zero_nxt = (xorResult == ZERO_BYTE);
            end
            STX_OP_XOR_TO_MEMORY: begin
              memWr_nxt = '{en: 1'b1, addr: req.addr, data: xorResult};
              zero_nxt = (xorResult == ZERO_BYTE);
            end
            default: begin
            end
          endcase
          if (req.op == STX_OP_TABLE_READ_PAGED || req.op == STX_OP_TABLE_READ_LAST_PAGE) begin
            tableOp_nxt = req.op;
            tableDst_nxt = req.addr;
            state_nxt = STX_ST_TABLE;
          end else if (skipTaken) begin
            skip_nxt = 1'b1;
            state_nxt = STX_ST_DUMMY;
          end else begin
            done_nxt = 1'b1;
          end
        end
      end
      STX_ST_TABLE: begin
        memWr_nxt = '{en: 1'b1, addr: tableDst_r, data: progWord[DATA_W-1:0]};
        tbl_nxt = progWord[PWORD_W-1:DATA_W];
        done_nxt = 1'b1;
        state_nxt = STX_ST_IDLE;
      end
      STX_ST_DUMMY: begin
        done_nxt = 1'b1;
        state_nxt = STX_ST_IDLE;
      end
      default: state_nxt = STX_ST_IDLE;
    endcase
    // Busy is registered so the port comes straight from a flip-flop
    busy_nxt = (state_nxt != STX_ST_IDLE);
  end

  // Registers
  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= STX_ST_IDLE;
      tableOp_r <= STX_OP_NONE;
      tableDst_r <= RESET_BYTE;
      progAddr_r <= RESET_PADDR;
      progRdEn_r <= 1'b0;
      memWr_r <= '0;
      acc_r <= RESET_BYTE;
      tbl_r <= RESET_BYTE;
      zero_r <= 1'b0;
      skip_r <= 1'b0;
      done_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tableOp_r <= tableOp_nxt;
      tableDst_r <= tableDst_nxt;
      progAddr_r <= progAddr_nxt;
      progRdEn_r <= progRdEn_nxt;
      memWr_r <= memWr_nxt;
      acc_r <= acc_nxt;
      tbl_r <= tbl_nxt;
      zero_r <= zero_nxt;
      skip_r <= skip_nxt;
      done_r <= done_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign busy = busy_r;
  assign progAddr = progAddr_r;
  assign progRdEn = progRdEn_r;
  assign memWr = memWr_r;
  assign acc = acc_r;
  assign tableHighByteLatch = tbl_r;
  assign zeroFlag = zero_r;
  assign skipNext = skip_r;
  assign done = done_r;

  // ==========================================================
  // Assertions
  wire isReq = reqValid && (state_r == STX_ST_IDLE);

  AST_BYTE_WB: assert property (@(posedge clock) disable iff (reset)
    isReq && req.op == STX_OP_SKIP_IF_BYTE_ZERO |=>
      memWr.en && memWr.data == $past(memRdData) && skipNext == ($past(memRdData) == 8'h00))
    else $error("byte zero-skip write-back or decision wrong");
  AST_SKIP_TWO: assert property (@(posedge clock) disable iff (reset)
    skipNext |-> busy ##1 (done && !busy))
    else $error("taken skip did not last two cycles");
  AST_NO_SKIP: assert property (@(posedge clock) disable iff (reset)
    isReq && !skipTaken && req.op inside {STX_OP_SKIP_IF_BYTE_ZERO, STX_OP_SKIP_IF_BIT_ZERO}
      |=> done && !skipNext)
    else $error("nonzero test skipped");
  AST_COPY: assert property (@(posedge clock) disable iff (reset)
    isReq && req.op == STX_OP_COPY_SKIP_IF_ZERO |=>
      acc == $past(memRdData) && skipNext == ($past(memRdData) == 8'h00))
    else $error("copy-and-skip wrong");
  AST_BIT: assert property (@(posedge clock) disable iff (reset)
    isReq && req.op == STX_OP_SKIP_IF_BIT_ZERO |=> skipNext == !$past(memRdData[req.bitSel]))
    else $error("bit zero-skip decision wrong");
  AST_FLAGS: assert property (@(posedge clock) disable iff (reset)
    isReq && !(req.op inside {STX_OP_XOR_TO_ACC, STX_OP_XOR_TO_MEMORY, STX_OP_XOR_IMMEDIATE})
      |=> $stable(zeroFlag) ##1 (!$past(busy) || $stable(zeroFlag)))
    else $error("flag changed by non-XOR instruction");
  AST_LAST_PAGE: assert property (@(posedge clock) disable iff (reset)
    isReq && req.op == STX_OP_TABLE_READ_LAST_PAGE |=>
      progRdEn && progAddr == {4'hF, $past(tablePointerLow)} ##1 memWr.en && done)
    else $error("last-page table read wrong");
  AST_TABLE_DATA: assert property (@(posedge clock) disable iff (reset)
    state_r == STX_ST_TABLE |=> memWr.data == $past(progWord[7:0]) &&
      tableHighByteLatch == $past(progWord[15:8]))
    else $error("table bytes misplaced");
  AST_XOR_MEM: assert property (@(posedge clock) disable iff (reset)
    isReq && req.op == STX_OP_XOR_TO_MEMORY |=>
      memWr.data == ($past(acc) ^ $past(memRdData)) && $stable(acc))
    else $error("XOR to memory wrong");
  AST_XOR_ZERO: assert property (@(posedge clock) disable iff (reset)
    isReq && req.op == STX_OP_XOR_IMMEDIATE |=>
      acc == ($past(acc) ^ $past(req.immediate)) && zeroFlag == (acc == 8'h00))
    else $error("immediate XOR or zero flag wrong");

  COV_SKIP: cover property (@(posedge clock) disable iff (reset) skipNext ##1 done);
  COV_TABLE: cover property (@(posedge clock) disable iff (reset) state_r == STX_ST_TABLE);
  COV_XOR_ZERO: cover property (@(posedge clock) disable iff (reset) $rose(zeroFlag));
endmodule : skip_table_xor_exec

// ==== verilog/stx_alu.sv ====
// Combinational compute unit: XOR, zero test and bit test
`timescale 1ns/1ps
module stx_alu (
  input wire stx_pkg::stx_op_e op,
  input wire logic [stx_pkg::DATA_W-1:0] acc,
  input wire logic [stx_pkg::DATA_W-1:0] memData,
  input wire logic [stx_pkg::DATA_W-1:0] immediate,
  input wire logic [stx_pkg::BIT_SEL_W-1:0] bitSel,
  output logic [stx_pkg::DATA_W-1:0] xorResult,
  output logic skipTaken
);
  import stx_pkg::*;

  // ==========================================================
  // XOR source select and skip decision on the operand as read
  always_comb begin
    xorResult = acc ^ ((op == STX_OP_XOR_IMMEDIATE) ? immediate : memData);
    unique case (op)
      STX_OP_SKIP_IF_BYTE_ZERO: skipTaken = (memData == ZERO_BYTE);
      STX_OP_COPY_SKIP_IF_ZERO: skipTaken = (memData == ZERO_BYTE);
      STX_OP_SKIP_IF_BIT_ZERO: skipTaken = ~memData[bitSel];
      default: skipTaken = 1'b0;
    endcase
  end
endmodule : stx_alu
